// [rtl/lock_gate_consts.vh]
// Constants for the parameter write lock gate: lock codes, function numbers,
// message codes and timing counts.
// Assumes a 10 MHz logic clock and a front panel that delivers one-cycle key events.
//
// Operation
// - Locked: refuse parameter edits, flash rejection, menu.
// - Locked: refuse restricted utility functions.
// - Locked: permitted view functions and reset still run.
// - Refused function never starts; flash rejection, menu.
// - Lock code 0000 permits, 0001 prohibits; default permits.
// - New lock value acts only after power-up.
// - Mode key stores value; flash completion, restore screen.
// - Other lock values show error, not stored.
`ifndef LOCK_GATE_CONSTS_VH
`define LOCK_GATE_CONSTS_VH

// ============================================================
// Lock setting codes
`define LOCK_PERMIT      16'h0000
`define LOCK_PROHIBIT    16'h0001
`define LOCK_DEFAULT     16'h0000

// ============================================================
// Utility function numbers
`define FN_ALARM_HIST    12'h000
`define FN_MOTOR_MODEL   12'h011
`define FN_VERSION       12'h012
`define FN_UNIT_ID       12'h01E
`define FN_SOFT_RESET    12'h030
`define FN_LOCK_SETTING  12'h010

// ============================================================
// Panel message codes
`define MSG_NONE         2'h0
`define MSG_REJECT       2'h1
`define MSG_DONE         2'h2
`define MSG_ERROR        2'h3

// ============================================================
// Timing: message flash time in microseconds and derived clock count
`define CLK_MHZ          10
`define FLASH_US         1000000
`define FLASH_CYCLES     (`FLASH_US * `CLK_MHZ)

`endif

// [rtl/function_permit.v]
// Decodes a utility function number into "may run while locked".
// Assumes the function number is stable while it is being looked at.
`timescale 1ns/100ps
`include "lock_gate_consts.vh"

module function_permit
(
   fn_number,
   allowed_locked
);
   input  wire [11:0] fn_number;      // Requested utility function number.
   output wire        allowed_locked; // High when the function may run while locked.

   // ============================================================
   // Permitted list: views and software reset; the lock function itself stays open.
   assign allowed_locked = (fn_number == `FN_ALARM_HIST)   ||
                           (fn_number == `FN_MOTOR_MODEL)  ||
                           (fn_number == `FN_VERSION)      ||
                           (fn_number == `FN_UNIT_ID)      ||
                           (fn_number == `FN_SOFT_RESET)   ||
                           (fn_number == `FN_LOCK_SETTING);
endmodule

// [rtl/parameter_write_lock_gate.v]
// Write lock gate for the drive's parameter store and utility functions.
// Assumes the panel logic raises one-cycle request pulses, that the stored lock
// value lives in nonvolatile storage presented on nv_lock_value, and that the
// storage accepts a write on the cycle nv_write is high.
`timescale 1ns/100ps
`include "lock_gate_consts.vh"

module parameter_write_lock_gate
#(
   parameter FLASH_CYCLES = `FLASH_CYCLES  // Length of a flashed message in clocks.
)
(
   clk,
   arst_n,
   nv_lock_value,
   param_write_req,
   fn_start_req,
   fn_number,
   lock_store_req,
   lock_entry_value,
   param_write_grant,
   fn_start_grant,
   nv_write,
   nv_write_data,
   flash_msg,
   flash_active,
   go_main_menu,
   restore_screen,
   locked
);
   input  wire        clk;               // 10 MHz logic clock.
   input  wire        arst_n;            // Asynchronous power-on reset, active low.
   input  wire [15:0] nv_lock_value;     // Lock value read from nonvolatile storage.
   input  wire        param_write_req;   // Pulse: operator tries to change a parameter.
   input  wire        fn_start_req;      // Pulse: operator tries to run a utility function.
   input  wire [11:0] fn_number;         // Function number with fn_start_req.
   input  wire        lock_store_req;    // Pulse: mode key pressed in lock function.
   input  wire [15:0] lock_entry_value;  // Value chosen with up and down.
   output reg         param_write_grant; // Pulse: parameter change goes ahead.
   output reg         fn_start_grant;    // Pulse: utility function may start.
   output reg         nv_write;          // Pulse: write the new lock value.
   output reg  [15:0] nv_write_data;     // Lock value to be written.
   output reg  [1:0]  flash_msg;         // Message being shown.
   output wire        flash_active;      // High while a message is shown.
   output reg         go_main_menu;      // Pulse: return to the main menu.
   output reg         restore_screen;    // Pulse: restore the previous screen.
   output wire        locked;            // Enforcement flag for this power cycle.

   // ============================================================
   // State codes of the message sequencer.
   localparam ST_IDLE  = 2'd0;  // Waiting for a request.
   localparam ST_FLASH = 2'd1;  // Showing a message.

   reg  [1:0]  state_q;         // Sequencer state.
   reg  [1:0]  state_d;         // Next sequencer state.
   reg  [31:0] flash_cnt_q;     // Cycles left in the current message.
   reg  [31:0] flash_cnt_d;     // Next value of the counter.
   reg  [1:0]  msg_q;           // Message held during the flash.
   reg  [1:0]  msg_d;           // Next message.
   reg         to_menu_q;       // Ending the flash returns to the main menu.
   reg         to_menu_d;       // Next value of the menu flag.
   reg         lock_q;          // Latched enforcement flag.
   reg         latched_q;       // Flag has been captured since reset.
   wire        fn_ok_locked;    // Function is on the permitted list.
   reg         grant_p_d;       // Next parameter grant.
   reg         grant_f_d;       // Next function grant.
   reg         nv_wr_d;         // Next storage write strobe.
   reg         menu_d;          // Next menu pulse.
   reg         restore_d;       // Next restore pulse.

   // ============================================================
   // Permitted function decode.
   function_permit u_permit
   (
      .fn_number      (fn_number),
      .allowed_locked (fn_ok_locked)
   );

   // ============================================================
   // Enforcement flag: reset to the factory permit state, captured from storage
   // on the first clock after release, then frozen until the next reset so a
   // new store only acts at the next power-up.
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lock_q    <= 1'b0;
         latched_q <= 1'b0;
      end
      else if (!latched_q)
      begin
         lock_q    <= (nv_lock_value == `LOCK_PROHIBIT);
         latched_q <= 1'b1;
      end
   end

   // While the flag is still being captured the gate refuses, to be safe.
   assign locked       = lock_q | ~latched_q;
   assign flash_active = (state_q == ST_FLASH);

   // ============================================================
   // Request decode and message sequencer.
   always @*
   begin
      state_d     = state_q;
      flash_cnt_d = flash_cnt_q;
      msg_d       = msg_q;
      to_menu_d   = to_menu_q;
      grant_p_d   = 1'b0;
      grant_f_d   = 1'b0;
      nv_wr_d     = 1'b0;
      menu_d      = 1'b0;
      restore_d   = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            // Requests are taken one at a time; store has priority, then edits.
            if (lock_store_req)
            begin
               state_d     = ST_FLASH;
               flash_cnt_d = FLASH_CYCLES - 1;
               to_menu_d   = 1'b0;
               if ((lock_entry_value == `LOCK_PERMIT) ||
                   (lock_entry_value == `LOCK_PROHIBIT))
               begin
                  // Store only; the flag is untouched until reset.
                  nv_wr_d = 1'b1;
                  msg_d   = `MSG_DONE;
               end
               else
               begin
                  msg_d = `MSG_ERROR;
               end
            end
            else if (param_write_req)
            begin
               if (locked)
               begin
                  state_d     = ST_FLASH;
                  flash_cnt_d = FLASH_CYCLES - 1;
                  msg_d       = `MSG_REJECT;
                  to_menu_d   = 1'b1;
               end
               else
               begin
                  grant_p_d = 1'b1;
               end
            end
            else if (fn_start_req)
            begin
               if (locked && !fn_ok_locked)
               begin
                  state_d     = ST_FLASH;
                  flash_cnt_d = FLASH_CYCLES - 1;
                  msg_d       = `MSG_REJECT;
                  to_menu_d   = 1'b1;
               end
               else
               begin
                  grant_f_d = 1'b1;
               end
            end
         end
         ST_FLASH:
         begin
            if (flash_cnt_q == 32'h0000_0000)
            begin
               state_d   = ST_IDLE;
               msg_d     = `MSG_NONE;
               menu_d    = to_menu_q;
               restore_d = ~to_menu_q;
            end
            else
            begin
               flash_cnt_d = flash_cnt_q - 32'h0000_0001;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
            msg_d   = `MSG_NONE;
         end
      endcase
   end

   // ============================================================
   // Sequencer and output registers.
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q           <= ST_IDLE;
         flash_cnt_q       <= 32'h0000_0000;
         msg_q             <= `MSG_NONE;
         to_menu_q         <= 1'b0;
         param_write_grant <= 1'b0;
         fn_start_grant    <= 1'b0;
         nv_write          <= 1'b0;
         nv_write_data     <= `LOCK_DEFAULT;
         flash_msg         <= `MSG_NONE;
         go_main_menu      <= 1'b0;
         restore_screen    <= 1'b0;
      end
      else
      begin
         state_q           <= state_d;
         flash_cnt_q       <= flash_cnt_d;
         msg_q             <= msg_d;
         to_menu_q         <= to_menu_d;
         param_write_grant <= grant_p_d;
         fn_start_grant    <= grant_f_d;
         nv_write          <= nv_wr_d;
         flash_msg         <= msg_d;
         go_main_menu      <= menu_d;
         restore_screen    <= restore_d;
         if (nv_wr_d)
         begin
            nv_write_data <= lock_entry_value;
         end
      end
   end
endmodule

// [bench/lock_gate_assertions.sv]
// Checker for the parameter write lock gate, bound to its top-level ports.
// Assumes one clock domain and the asynchronous active-low power-on reset.
`timescale 1ns/100ps

module lock_gate_assertions
(
   input logic        clk,
   input logic        arst_n,
   input logic        param_write_req,
   input logic        fn_start_req,
   input logic [11:0] fn_number,
   input logic        lock_store_req,
   input logic [15:0] lock_entry_value,
   input logic        param_write_grant,
   input logic        fn_start_grant,
   input logic        nv_write,
   input logic [15:0] nv_write_data,
   input logic [1:0]  flash_msg,
   input logic        flash_active,
   input logic        go_main_menu,
   input logic        restore_screen,
   input logic        locked
);
   // ============================================================
   // Request decode, with store ahead of edit ahead of function start.
   logic st_tk;   // A lock store is taken.
   logic edit_tk; // A parameter edit is taken.
   logic fn_tk;   // A function start is taken.
   logic fn_ok;   // The function may run while locked.
   assign st_tk   = lock_store_req && !flash_active;
   assign edit_tk = param_write_req && !flash_active && !lock_store_req;
   assign fn_tk   = fn_start_req && !flash_active && !lock_store_req && !param_write_req;
   assign fn_ok   = fn_number inside {12'h000, 12'h010, 12'h011, 12'h012, 12'h01E, 12'h030};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // ============================================================
   // The first six properties tie each answer to the request one cycle earlier; the last three check the flag and the end of a flash.
   a_edit_refused: assert property (edit_tk && locked |=>
      flash_msg == 2'h1 && !param_write_grant) else $error("locked edit not refused");
   a_edit_granted: assert property (edit_tk && !locked |=>
      param_write_grant && !flash_active) else $error("free edit not granted");
   a_fn_refused: assert property (fn_tk && locked && !fn_ok |=>
      !fn_start_grant && flash_msg == 2'h1) else $error("restricted function started");
   a_fn_allowed: assert property (fn_tk && (fn_ok || !locked) |=>
      fn_start_grant && !flash_active) else $error("permitted function refused");
   a_store_good: assert property (st_tk && lock_entry_value <= 16'h0001 |=> nv_write &&
      nv_write_data == $past(lock_entry_value) && flash_msg == 2'h2) else $error("store failed");
   a_store_bad: assert property (st_tk && lock_entry_value > 16'h0001 |=>
      !nv_write && flash_msg == 2'h3 ##1 !nv_write) else $error("bad lock value accepted");
   a_lock_held: assert property (arst_n [*3] |-> $stable(locked))
      else $error("lock flag moved between resets");
   a_reject_menu: assert property ($fell(flash_active) && $past(flash_msg) == 2'h1
      |-> go_main_menu) else $error("no return to main menu");
   a_done_restore: assert property ($fell(flash_active) && $past(flash_msg) >= 2'h2
      |-> restore_screen && !go_main_menu) else $error("screen not restored");

   cover property (fn_tk && locked && !fn_ok);
   cover property (st_tk && lock_entry_value > 16'h0001);
   cover property ($fell(flash_active) && go_main_menu);
endmodule

bind parameter_write_lock_gate lock_gate_assertions i_chk (.*);

// [bench/lock_store_model.sv]
// Nonvolatile store that holds the lock value across power cycles.
// Assumes the gate writes it with a one-cycle nv_write pulse.
`timescale 1ns/100ps

module lock_store_model
(
   input  logic        clk,
   input  logic        nv_write,
   input  logic [15:0] nv_write_data,
   output logic [15:0] nv_lock_value
);
   // Factory value permits writing; it survives every reset.
   initial nv_lock_value = 16'h0000;
   // A store lands at once but is only read by the gate at power-up.
   always @(posedge clk)
      if (nv_write)
         nv_lock_value <= nv_write_data;
endmodule

// [bench/parameter_write_lock_gate_tb.sv]
// Self-checking bench for the lock gate with a short flash time.
// Assumes the lock store model and the bound checker are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module parameter_write_lock_gate_tb;
   logic clk = 0, arst_n = 0, param_write_req = 0, fn_start_req = 0, lock_store_req = 0;
   logic [11:0] fn_number = 12'h000;
   logic [15:0] lock_entry_value = 16'h0000, nv_lock_value, nv_write_data, nvd = 16'h0000, bad;
   logic        param_write_grant, fn_start_grant, nv_write, flash_active;
   logic        go_main_menu, restore_screen, locked;
   logic [1:0]  flash_msg, lastm = 2'h0;
   logic [19:0] exp_q[$], got, ex;
   logic [3:0]  code;
   int          error_cnt = 0, n_checks = 0;
   logic [11:0] rfn[24] = '{12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h009, 12'h00A,
      12'h00B, 12'h00C, 12'h00D, 12'h00E, 12'h00F, 12'h014, 12'h01B, 12'h020, 12'h080,
      12'h200, 12'h201, 12'h202, 12'h203, 12'h204, 12'h205, 12'h206, 12'h207};
   logic [11:0] pfn[6] = '{12'h000, 12'h010, 12'h011, 12'h012, 12'h01E, 12'h030};

   initial forever #50 clk = ~clk;

   parameter_write_lock_gate #(.FLASH_CYCLES(4)) i_dut (.clk(clk), .arst_n(arst_n),
      .nv_lock_value(nv_lock_value), .param_write_req(param_write_req),
      .fn_start_req(fn_start_req), .fn_number(fn_number), .lock_store_req(lock_store_req),
      .lock_entry_value(lock_entry_value), .param_write_grant(param_write_grant),
      .fn_start_grant(fn_start_grant), .nv_write(nv_write), .nv_write_data(nv_write_data),
      .flash_msg(flash_msg), .flash_active(flash_active), .go_main_menu(go_main_menu),
      .restore_screen(restore_screen), .locked(locked));
   lock_store_model i_nv (.clk(clk), .nv_write(nv_write), .nv_write_data(nv_write_data),
      .nv_lock_value(nv_lock_value));

   // Prints the counts and the verdict, then stops.
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Holds reset 20 cycles, as a power cycle would.
   task power_cycle;
      @(negedge clk);
      arst_n = 0;
      repeat (20) @(negedge clk);
      arst_n = 1;
      repeat (2) @(negedge clk);
   endtask

   // Pulses one request (0 edit, 1 function, 2 store) and waits for its answer.
   task automatic req(input logic [1:0] k, input logic [15:0] v, input logic [19:0] e);
      int i;
      @(negedge clk);
      param_write_req = (k == 2'h0);
      fn_start_req = (k == 2'h1);
      lock_store_req = (k == 2'h2);
      fn_number = v[11:0];
      lock_entry_value = v;
      exp_q.push_back(e);
      @(negedge clk);
      {param_write_req, fn_start_req, lock_store_req} = 3'h0;
      fn_number = 12'($urandom);
      lock_entry_value = 16'($urandom);
      for (i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge clk);
   endtask

   // Turns each visible outcome into a code and checks it against the oldest note.
   always @(posedge clk)
      if (arst_n)
      begin
         if (nv_write) nvd = nv_write_data;
         if (flash_msg != 2'h0) lastm = flash_msg;
         code = param_write_grant ? 4'h1 : fn_start_grant ? 4'h2 : go_main_menu ? 4'h3 :
                restore_screen ? (lastm == 2'h3 ? 4'h5 : 4'h4) : 4'h0;
         if (code != 4'h0)
         begin
            got = {code, (code == 4'h4) ? nvd : 16'h0000};
            ex = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK(got, ex)
         end
      end

   // Main sequence: unlocked run, locked run, then unlock again.
   initial begin
      void'($urandom(26565));
      power_cycle;
      `CHK(locked, 1'b0)
      req(2'h0, 16'h0000, {4'h1, 16'h0000});
      req(2'h1, 16'h0002, {4'h2, 16'h0000});
      req(2'h2, 16'h0001, {4'h4, 16'h0001});
      `CHK(locked, 1'b0)
      req(2'h0, 16'h0000, {4'h1, 16'h0000});
      $display("test unlocked done");
      power_cycle;
      `CHK(locked, 1'b1)
      req(2'h0, 16'h0000, {4'h3, 16'h0000});
      foreach (rfn[i]) req(2'h1, {4'h0, rfn[i]}, {4'h3, 16'h0000});
      foreach (pfn[i]) req(2'h1, {4'h0, pfn[i]}, {4'h2, 16'h0000});
      bad = 16'($urandom) | 16'h0002;
      req(2'h2, bad, {4'h5, 16'h0000});
      req(2'h2, 16'h0000, {4'h4, 16'h0000});
      `CHK(locked, 1'b1)
      $display("test locked done");
      power_cycle;
      `CHK(locked, 1'b0)
      `CHK(32'(exp_q.size()), 32'h0000_0000)
      $display("test unlock done");
      conclude;
   end

   // Cuts a hang short well after the expected run length.
   initial begin
      #5_000_000;
      error_cnt++;
      conclude;
   end
endmodule
